//--- common/pdt_pkg.sv
package pdt_pkg;

  // Register offsets on the five register-select lines
  localparam logic [4:0] OFS_CONTROL   = 5'h10;
  localparam logic [4:0] OFS_VECTOR    = 5'h11;
  localparam logic [4:0] OFS_PRE_NULL  = 5'h12;
  localparam logic [4:0] OFS_PRE_HIGH  = 5'h13;
  localparam logic [4:0] OFS_PRE_MID   = 5'h14;
  localparam logic [4:0] OFS_PRE_LOW   = 5'h15;
  localparam logic [4:0] OFS_CNT_NULL  = 5'h16;
  localparam logic [4:0] OFS_CNT_HIGH  = 5'h17;
  localparam logic [4:0] OFS_CNT_MID   = 5'h18;
  localparam logic [4:0] OFS_CNT_LOW   = 5'h19;
  localparam logic [4:0] OFS_FLAGS     = 5'h1A;

  // Control and flag register field positions
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_CLK_LSB    = 1;
  localparam int CTL_CLK_MSB    = 2;
  localparam int CTL_UNUSED_BIT = 3;
  localparam int CTL_ZD_BIT     = 4;
  localparam int CTL_PIN_LSB    = 5;
  localparam int CTL_PIN_MSB    = 7;
  localparam int FLAG_ZD_BIT    = 0;

  // Reset and fixed values
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  VECTOR_RESET  = 8'h0F;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
  localparam logic [4:0]  PRESCALE_TOP  = 5'h1F;
  localparam logic [4:0]  PRESCALE_ZERO = 5'h00;
  localparam logic [23:0] COUNT_ZERO    = 24'h000000;
  localparam logic [23:0] COUNT_ONE     = 24'h000001;

  // Clock control field
  localparam logic [1:0] CLK_SYS        = 2'h0;
  localparam logic [1:0] CLK_SYS_GATED  = 2'h1;
  localparam logic [1:0] CLK_TIN_PRE    = 2'h2;
  localparam logic [1:0] CLK_TIN_DIRECT = 2'h3;

  // Output and acknowledge pin field
  localparam logic [2:0] PIN_INT_OFF_ACK = 3'h4;
  localparam logic [2:0] PIN_INT_VECTOR  = 3'h5;
  localparam logic [2:0] PIN_INT_OFF     = 3'h6;
  localparam logic [2:0] PIN_INT_AUTO    = 3'h7;

  // Input synchroniser width: TIMER_INPUT_PIN, ack, select, rw, 5 address, 8 data
  localparam int SYNC_WIDTH = 17;
  localparam logic [16:0] SYNC_INIT = 17'h0FFFF;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } pdt_bus_state_t;

endpackage

//--- core/pdt_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pdt_sync #(
  parameter int                 WIDTH = 1,
  parameter logic [WIDTH-1:0]   INIT  = '0
) (
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // Two flops; only the second stage is visible outside
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stage_one <= INIT;
      sync_out  <= INIT;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // pdt_sync
`default_nettype wire

//--- core/pdt_timer.sv
// Summary of operation
// - Field 00X: both shared pins are port pins
// - Field 01X: square wave, high when halted
// - Field 100: output floats, acknowledge ignored
// - Field 101: request low on flag, vectored
// - Field 110: output floats, acknowledge pin port
// - Field 111: request low on flag, autovectored
// - Bit 4 low: reload after zero detect
// - Bit 4 high: roll over, no reload
// - Control bit 3 always reads zero
// - Clock 00: system prescaled, enable alone runs
// - Clock 01: run needs enable and input high
// - Clock 10: prescaler steps on input rising
// - Clock 11: counter steps on input rising
// - Enable bit selects run or halt
// - Vector same on read and acknowledge; 0F
// - Preload bytes addressable; null reads zero
// - Count bytes live, writes ignored, null zero
// - Flag set on count one to zero
// - Flag clear by write-one or halt, clear wins
// - Flag bits 7-1 zero; reads harmless
// - Reset halts timer and clears flag
// - Halted: count held, prescaler forced 1F
// - First rollover after run loads preload
`timescale 1ns/100ps
`default_nettype none
module pdt_timer (
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       CS_N,
  input  wire logic       RW,
  input  wire logic [4:0] RS,
  input  wire logic [7:0] D_IN,
  output logic      [7:0] D_OUT,
  output logic            D_OE,
  output logic            BUS_DATA_ACK_N_OUT,
  output logic            BUS_DATA_ACK_OE,
  input  wire logic       TIMER_INPUT_PIN,
  input  wire logic       TIMER_IRQ_ACK_PIN_N,
  output logic            TIMER_OUTPUT_PIN_OUT,
  output logic            TIMER_OUTPUT_PIN_OE,
  output logic            PORT_PIN_THREE_SEL,
  output logic            PORT_PIN_SEVEN_SEL,
  output logic            PORT_PIN_TWO_SEL
);

  import pdt_pkg::*;

  // Synchronised pins
  logic [SYNC_WIDTH-1:0] sync_bus;
  wire logic             tin_s;
  wire logic             ack_n_s;
  wire logic             cs_n_s;
  wire logic             rw_s;
  wire logic [4:0]       rs_s;
  wire logic [7:0]       din_s;

  // Registers
  logic [7:0]     timer_control;
  logic [7:0]     timer_vector;
  logic [7:0]     preload_high;
  logic [7:0]     preload_mid;
  logic [7:0]     preload_low;
  logic [23:0]    counter;
  logic [4:0]     prescaler;
  logic           loaded;
  logic           zero_detect_flag;
  logic           square;
  logic           tin_prev;
  pdt_bus_state_t bus_state;

  // Next values and decodes
  wire logic [2:0]  pin_mode;
  wire logic [1:0]  clk_mode;
  wire logic        roll_over;
  wire logic        enable;
  wire logic        run;
  wire logic        tin_rise;
  wire logic        presc_step;
  wire logic        tick;
  wire logic [23:0] preload_value;
  wire logic        count_is_zero;
  wire logic        zero_hit;
  wire logic [4:0]  next_prescaler;
  wire logic [23:0] next_counter;
  wire logic        next_loaded;
  wire logic        bus_req;
  wire logic        ack_req;
  wire logic        start;
  wire logic        wr;
  wire logic        flag_clear;
  wire logic        next_zero_detect_flag;
  wire logic        next_square;
  wire logic [7:0]  rd_data;
  wire logic [7:0]  next_d_out;
  wire logic        square_mode;
  wire logic        int_enabled;
  wire logic        next_timer_output_pin_out;
  wire logic        next_timer_output_pin_oe;
  wire logic        bus_release;

  pdt_sync #(
    .WIDTH (SYNC_WIDTH),
    .INIT  (SYNC_INIT)
  ) u_sync (
    .CLK      (CLK),
    .RESET_N  (RESET_N),
    .async_in ({TIMER_INPUT_PIN, TIMER_IRQ_ACK_PIN_N, CS_N, RW, RS, D_IN}),
    .sync_out (sync_bus)
  );

  assign tin_s   = sync_bus[16];
  assign ack_n_s = sync_bus[15];
  assign cs_n_s  = sync_bus[14];
  assign rw_s    = sync_bus[13];
  assign rs_s    = sync_bus[12:8];
  assign din_s   = sync_bus[7:0];

  assign pin_mode  = timer_control[CTL_PIN_MSB:CTL_PIN_LSB];
  assign clk_mode  = timer_control[CTL_CLK_MSB:CTL_CLK_LSB];
  assign roll_over = timer_control[CTL_ZD_BIT];
  assign enable    = timer_control[CTL_ENABLE_BIT];

  // Run or halt
  assign run = enable & ((clk_mode != CLK_SYS_GATED) | tin_s);

  assign tin_rise = tin_s & ~tin_prev;

  // Prescaler steps every clock for system modes, on input rising edge for clock 10, never for clock 11
  assign presc_step = run & (((clk_mode == CLK_SYS) | (clk_mode == CLK_SYS_GATED))
                      | ((clk_mode == CLK_TIN_PRE) & tin_rise));

  assign tick = (clk_mode == CLK_TIN_DIRECT) ? (run & tin_rise)
              : (presc_step & (prescaler == PRESCALE_ZERO));

  assign next_prescaler = !run       ? PRESCALE_TOP
                        : presc_step ? prescaler - 5'h01
                        : prescaler;

  assign preload_value = {preload_high, preload_mid, preload_low};
  assign count_is_zero = (counter == COUNT_ZERO);

  // Preload transfer on the first step after entering run
  assign next_counter = !tick                       ? counter
                      : !loaded                     ? preload_value
                      : (count_is_zero & !roll_over) ? preload_value
                      : counter - COUNT_ONE;

  assign next_loaded = run & (loaded | tick);

  assign zero_hit = tick & loaded & (counter == COUNT_ONE);

  // Bus and acknowledge requests
  assign bus_req = ~cs_n_s;
  assign ack_req = ~ack_n_s & (pin_mode == PIN_INT_VECTOR) & zero_detect_flag;
  assign start   = (bus_state == BUS_IDLE) & (bus_req | ack_req);
  assign wr      = (bus_state == BUS_IDLE) & bus_req & ~rw_s;
  assign bus_release = cs_n_s & ack_n_s;

  // Clear dominates a simultaneous zero detect
  assign flag_clear = !run | (wr & (rs_s == OFS_FLAGS) & din_s[FLAG_ZD_BIT]);
  assign next_zero_detect_flag = flag_clear ? 1'b0
                               : zero_hit   ? 1'b1
                               : zero_detect_flag;

  // Square wave: high in halt, toggles on zero detect
  assign next_square = !run     ? 1'b1
                     : zero_hit ? ~square
                     : square;

  // Read data selection
  assign rd_data =
      (rs_s == OFS_CONTROL)  ? {timer_control[7:4], 1'b0, timer_control[2:0]}
    : (rs_s == OFS_VECTOR)   ? timer_vector
    : (rs_s == OFS_PRE_HIGH) ? preload_high
    : (rs_s == OFS_PRE_MID)  ? preload_mid
    : (rs_s == OFS_PRE_LOW)  ? preload_low
    : (rs_s == OFS_CNT_HIGH) ? counter[23:16]
    : (rs_s == OFS_CNT_MID)  ? counter[15:8]
    : (rs_s == OFS_CNT_LOW)  ? counter[7:0]
    : (rs_s == OFS_FLAGS)    ? {7'h00, zero_detect_flag}
    : READ_ZERO;

  assign next_d_out = bus_req ? rd_data : timer_vector;

  // Pin function decode
  assign square_mode = (pin_mode[2:1] == 2'h1);
  assign int_enabled = (pin_mode == PIN_INT_VECTOR) | (pin_mode == PIN_INT_AUTO);
  assign next_timer_output_pin_out = square_mode ? next_square : 1'b0;
  assign next_timer_output_pin_oe  = square_mode
                       | (int_enabled & next_zero_detect_flag);

  // Control register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      timer_control <= CONTROL_RESET;
    end else if (wr && rs_s == OFS_CONTROL) begin
      timer_control <= {din_s[7:4], 1'b0, din_s[2:0]};
    end
  end

  // Vector register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      timer_vector <= VECTOR_RESET;
    end else if (wr && rs_s == OFS_VECTOR) begin
      timer_vector <= din_s;
    end
  end

  // Preload bytes keep their contents through reset
  always_ff @(posedge CLK) begin
    if (wr && rs_s == OFS_PRE_HIGH) begin
      preload_high <= din_s;
    end
    if (wr && rs_s == OFS_PRE_MID) begin
      preload_mid <= din_s;
    end
    if (wr && rs_s == OFS_PRE_LOW) begin
      preload_low <= din_s;
    end
  end

  // Counter keeps its contents through reset
  always_ff @(posedge CLK) begin
    counter <= next_counter;
  end

  // Timer control state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prescaler        <= PRESCALE_TOP;
      loaded           <= 1'b0;
      zero_detect_flag <= 1'b0;
      square           <= 1'b1;
      tin_prev         <= 1'b0;
    end else begin
      prescaler        <= next_prescaler;
      loaded           <= next_loaded;
      zero_detect_flag <= next_zero_detect_flag;
      square           <= next_square;
      tin_prev         <= tin_s;
    end
  end

  // Pin outputs and port function selects
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMER_OUTPUT_PIN_OUT <= 1'b0;
      TIMER_OUTPUT_PIN_OE  <= 1'b0;
      PORT_PIN_THREE_SEL   <= 1'b1;
      PORT_PIN_SEVEN_SEL   <= 1'b1;
      PORT_PIN_TWO_SEL     <= 1'b1;
    end else begin
      TIMER_OUTPUT_PIN_OUT <= next_timer_output_pin_out;
      TIMER_OUTPUT_PIN_OE  <= next_timer_output_pin_oe;
      PORT_PIN_THREE_SEL   <= (pin_mode[2:1] == 2'h0);
      PORT_PIN_SEVEN_SEL   <= (pin_mode != PIN_INT_OFF_ACK)
                            & (pin_mode != PIN_INT_VECTOR);
      PORT_PIN_TWO_SEL     <= (clk_mode == CLK_SYS);
    end
  end

  // Bus cycle: act once, hold acknowledge until select and ack negate
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_state   <= BUS_IDLE;
      D_OUT       <= READ_ZERO;
      D_OE        <= 1'b0;
      BUS_DATA_ACK_N_OUT <= 1'b1;
      BUS_DATA_ACK_OE    <= 1'b0;
    end else begin
      unique case (bus_state)
        BUS_IDLE: begin
          if (start) begin
            bus_state   <= BUS_ACK;
            D_OUT       <= next_d_out;
            D_OE        <= ~bus_req | rw_s;
            BUS_DATA_ACK_N_OUT <= 1'b0;
            BUS_DATA_ACK_OE    <= 1'b1;
          end
        end
        BUS_ACK: begin
          if (bus_release) begin
            bus_state   <= BUS_IDLE;
            D_OE        <= 1'b0;
            BUS_DATA_ACK_N_OUT <= 1'b1;
            BUS_DATA_ACK_OE    <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule // pdt_timer
`default_nettype wire

//--- tb/pdt_host.sv
`timescale 1ns/100ps
`default_nettype none
module pdt_host (
  input  wire logic       CLK,
  input  wire logic [7:0] D_OUT,
  input  wire logic       D_OE,
  input  wire logic       BUS_DATA_ACK_N_OUT,
  input  wire logic       BUS_DATA_ACK_OE,
  output logic            CS_N,
  output logic            RW,
  output logic      [4:0] RS,
  output logic      [7:0] D_IN,
  output logic            ACK_N
);
  initial begin
    CS_N = 1'b1;
    RW = 1'b1;
    RS = 5'h00;
    D_IN = 8'h00;
    ACK_N = 1'b1;
  end

  // One register or acknowledge cycle; gives up after ten edges
  task automatic cycle(input logic ack, input logic rw_i, input logic [4:0] rs_i,
                       input logic [7:0] wd, output logic got, output logic [7:0] rd);
    int n;
    got = 1'b0;
    rd = 8'h00;
    @(negedge CLK);
    RW = rw_i;
    RS = rs_i;
    D_IN = rw_i ? ~D_IN : wd;
    if (ack) begin
      ACK_N = 1'b0;
    end else begin
      CS_N = 1'b0;
    end
    for (n = 0; n < 10 && !got; n++) begin
      @(negedge CLK);
      if (BUS_DATA_ACK_OE === 1'b1 && BUS_DATA_ACK_N_OUT === 1'b0) begin
        got = 1'b1;
        // Undriven data lines read back inverted
        rd = (D_OE === 1'b1) ? D_OUT : ~D_OUT;
      end
    end
    @(negedge CLK);
    CS_N = 1'b1;
    ACK_N = 1'b1;
    // Released data lines do not keep the last value
    D_IN = ~D_IN;
    for (n = 0; n < 10 && BUS_DATA_ACK_OE !== 1'b0; n++) @(posedge CLK);
  endtask
endmodule // pdt_host
`default_nettype wire

//--- tb/pdt_timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pdt_timer_monitor (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CS_N,
  input wire logic TIMER_IRQ_ACK_PIN_N,
  input wire logic D_OE,
  input wire logic BUS_DATA_ACK_N_OUT,
  input wire logic BUS_DATA_ACK_OE,
  input wire logic TIMER_OUTPUT_PIN_OUT,
  input wire logic TIMER_OUTPUT_PIN_OE,
  input wire logic PORT_PIN_THREE_SEL,
  input wire logic PORT_PIN_SEVEN_SEL,
  input wire logic PORT_PIN_TWO_SEL
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_ack_low_only: assert property (BUS_DATA_ACK_OE |-> !BUS_DATA_ACK_N_OUT)
    else $error("acknowledge driven high");
  a_data_with_ack: assert property (D_OE |-> BUS_DATA_ACK_OE)
    else $error("data driven without acknowledge");
  a_bus_answer: assert property ($fell(CS_N) |-> ##[2:4] BUS_DATA_ACK_OE)
    else $error("bus cycle not acknowledged");
  a_ack_holds: assert property (BUS_DATA_ACK_OE && !CS_N |=> BUS_DATA_ACK_OE)
    else $error("acknowledge dropped early");
  a_ack_release: assert property ($rose(CS_N) && TIMER_IRQ_ACK_PIN_N |-> ##[1:4] !BUS_DATA_ACK_OE)
    else $error("acknowledge not released");
  a_port_pin_idle: assert property (PORT_PIN_THREE_SEL |-> !TIMER_OUTPUT_PIN_OE)
    else $error("output driven in port mode");
  a_request_low: assert property (!PORT_PIN_SEVEN_SEL && TIMER_OUTPUT_PIN_OE |-> !TIMER_OUTPUT_PIN_OUT)
    else $error("request driven high");
  a_vector_answer: assert property ($fell(TIMER_IRQ_ACK_PIN_N) && CS_N && !PORT_PIN_SEVEN_SEL
    && TIMER_OUTPUT_PIN_OE |-> ##[2:4] (D_OE && BUS_DATA_ACK_OE))
    else $error("vector not supplied");
  a_ack_ignored: assert property ($fell(TIMER_IRQ_ACK_PIN_N) && CS_N && !PORT_PIN_SEVEN_SEL
    && !TIMER_OUTPUT_PIN_OE |-> (!BUS_DATA_ACK_OE)[*5])
    else $error("acknowledge answered without request");
  a_reset_state: assert property ($rose(RESET_N) |-> PORT_PIN_THREE_SEL && PORT_PIN_SEVEN_SEL
    && PORT_PIN_TWO_SEL && !BUS_DATA_ACK_OE)
    else $error("pins not in port state after reset");

  c_vector: cover property (D_OE && CS_N);
  c_request: cover property (TIMER_OUTPUT_PIN_OE && !TIMER_OUTPUT_PIN_OUT);
  c_tin_used: cover property (!PORT_PIN_TWO_SEL && TIMER_OUTPUT_PIN_OUT);
endmodule // pdt_timer_monitor

bind pdt_timer pdt_timer_monitor pdt_timer_monitor_inst (
  .CLK(CLK), .RESET_N(RESET_N), .CS_N(CS_N), .TIMER_IRQ_ACK_PIN_N(TIMER_IRQ_ACK_PIN_N),
  .D_OE(D_OE), .BUS_DATA_ACK_N_OUT(BUS_DATA_ACK_N_OUT), .BUS_DATA_ACK_OE(BUS_DATA_ACK_OE),
  .TIMER_OUTPUT_PIN_OUT(TIMER_OUTPUT_PIN_OUT), .TIMER_OUTPUT_PIN_OE(TIMER_OUTPUT_PIN_OE),
  .PORT_PIN_THREE_SEL(PORT_PIN_THREE_SEL), .PORT_PIN_SEVEN_SEL(PORT_PIN_SEVEN_SEL),
  .PORT_PIN_TWO_SEL(PORT_PIN_TWO_SEL));
`default_nettype wire

//--- tb/tb_pdt_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pdt_timer;
  import pdt_pkg::*;
  logic       clk, reset_n, cs_n, rw, bus_data_ack_n, bus_data_ack_oe, d_oe, timer_input_pin, ack_n;
  logic       timer_output_pin, timer_output_pin_oe, sel3, sel7, sel2, got;
  logic [4:0] rs;
  logic [7:0] d_in, d_out, rd;
  int         n_fail, samples_checked;

  pdt_timer pdt_timer_inst (
    .CLK(clk), .RESET_N(reset_n), .CS_N(cs_n), .RW(rw), .RS(rs), .D_IN(d_in),
    .D_OUT(d_out), .D_OE(d_oe), .BUS_DATA_ACK_N_OUT(bus_data_ack_n), .BUS_DATA_ACK_OE(bus_data_ack_oe),
    .TIMER_INPUT_PIN(timer_input_pin), .TIMER_IRQ_ACK_PIN_N(ack_n),
    .TIMER_OUTPUT_PIN_OUT(timer_output_pin), .TIMER_OUTPUT_PIN_OE(timer_output_pin_oe),
    .PORT_PIN_THREE_SEL(sel3), .PORT_PIN_SEVEN_SEL(sel7), .PORT_PIN_TWO_SEL(sel2));
  pdt_host pdt_host_inst (
    .CLK(clk), .D_OUT(d_out), .D_OE(d_oe), .BUS_DATA_ACK_N_OUT(bus_data_ack_n), .BUS_DATA_ACK_OE(bus_data_ack_oe),
    .CS_N(cs_n), .RW(rw), .RS(rs), .D_IN(d_in), .ACK_N(ack_n));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    pdt_host_inst.cycle(1'b0, 1'b0, a, v, got, rd);
    chk({7'h0, got}, 8'h01);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    pdt_host_inst.cycle(1'b0, 1'b1, a, 8'h00, got, rd);
    chk({7'h0, got}, 8'h01);
    chk(rd, exp);
  endtask
  task automatic preload(input logic [23:0] v);
    wr(OFS_PRE_HIGH, v[23:16]);
    wr(OFS_PRE_MID, v[15:8]);
    wr(OFS_PRE_LOW, v[7:0]);
    rdc(OFS_PRE_MID, v[15:8]);
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      @(negedge clk);
      timer_input_pin = 1'b1;
      repeat (3) @(negedge clk);
      timer_input_pin = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  task automatic wait_pin(input logic [1:0] want, input int lim);
    for (int i = 0; i < lim && {timer_output_pin_oe, timer_output_pin} !== want; i++) @(negedge clk);
  endtask

  task automatic t_reset;
    chk({5'h0, sel3, sel7, sel2}, 8'h07);
    rdc(OFS_CONTROL, CONTROL_RESET);
    rdc(OFS_VECTOR, VECTOR_RESET);
    rdc(OFS_FLAGS, 8'h00);
    wr(OFS_CONTROL, 8'hF8);
    rdc(OFS_CONTROL, 8'hF0);
    wr(OFS_VECTOR, 8'hA5);
    rdc(OFS_VECTOR, 8'hA5);
    wr(OFS_PRE_NULL, 8'hFF);
    rdc(OFS_PRE_NULL, 8'h00);
    rdc(OFS_CNT_NULL, 8'h00);
  endtask
  task automatic t_vector;
    preload(24'h000002);
    wr(OFS_CONTROL, 8'hA1);
    repeat (80) @(negedge clk);
    rdc(OFS_CNT_LOW, 8'h01);
    wait_pin(2'b10, 40);
    chk({6'h0, timer_output_pin_oe, timer_output_pin}, 8'h02);
    rdc(OFS_FLAGS, 8'h01);
    pdt_host_inst.cycle(1'b1, 1'b1, 5'h00, 8'h00, got, rd);
    chk(rd, 8'hA5);
    repeat (20) @(negedge clk);
    wr(OFS_CONTROL, 8'hA0);
    rdc(OFS_CNT_LOW, 8'h02);
    rdc(OFS_FLAGS, 8'h00);
  endtask
  task automatic t_roll;
    preload(24'h000001);
    wr(OFS_CONTROL, 8'hF7);
    pulse(2);
    chk({5'h0, sel7, timer_output_pin_oe, timer_output_pin}, 8'h06);
    pulse(1);
    rdc(OFS_CNT_HIGH, 8'hFF);
    wr(OFS_CNT_LOW, 8'h00);
    rdc(OFS_CNT_LOW, 8'hFF);
    wr(OFS_FLAGS, 8'h01);
    rdc(OFS_FLAGS, 8'h00);
  endtask
  task automatic t_modes;
    wr(OFS_CONTROL, 8'h80);
    pdt_host_inst.cycle(1'b1, 1'b1, 5'h00, 8'h00, got, rd);
    chk({5'h0, got, sel7, timer_output_pin_oe}, 8'h00);
    wr(OFS_CONTROL, 8'hC0);
    chk({5'h0, sel3, sel7, timer_output_pin_oe}, 8'h02);
  endtask
  task automatic t_square;
    wr(OFS_CONTROL, 8'h43);
    repeat (70) @(negedge clk);
    chk({5'h0, sel2, timer_output_pin_oe, timer_output_pin}, 8'h03);
    timer_input_pin = 1'b1;
    wait_pin(2'b10, 100);
    chk({6'h0, timer_output_pin_oe, timer_output_pin}, 8'h02);
    @(negedge clk);
    timer_input_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk({6'h0, timer_output_pin_oe, timer_output_pin}, 8'h03);
    rdc(OFS_FLAGS, 8'h00);
    wr(OFS_CONTROL, 8'h45);
    pulse(63);
    chk({7'h0, timer_output_pin}, 8'h01);
    pulse(1);
    chk({7'h0, timer_output_pin}, 8'h00);
  endtask

  task automatic report_and_stop;
    $display("TB: checks=%0d errors=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    n_fail = 0;
    samples_checked = 0;
    timer_input_pin = 1'b0;
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_vector();
    t_roll();
    t_modes();
    t_square();
    report_and_stop();
  end
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule // tb_pdt_timer
`default_nettype wire
